// >>> scc_pkg.sv
// Shared constants and types for the secondary cache snoop controller
package scc_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 64;
  localparam int LINES = 4;
  localparam int FIFO_DEPTH = 16;
  // Byte offset bits of a 32-byte and a 64-byte line
  localparam int OFS_32 = 5;
  localparam int OFS_64 = 6;
  // Double words per line, per line size
  localparam logic [3:0] BEATS_32 = 4'h4;
  localparam logic [3:0] BEATS_64 = 4'h8;
  // Beat index bit that selects the half of a 64-byte line
  localparam int HALF_BEAT_BIT = 2;
  typedef enum logic [1:0] {
    LS_INV = 2'h0,
    LS_SU = 2'h1,
    LS_EU = 2'h2,
    LS_EM = 2'h3
  } line_state_e;
  localparam line_state_e LINE_RESET = LS_INV;
  typedef enum logic [1:0] {
    SK_READ = 2'h0,
    SK_RWITM = 2'h1,
    SK_INVAL = 2'h2,
    SK_COPYBACK = 2'h3
  } sys_kind_e;
  // Gray codes in the order listed, each code one bit from the one above it
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_SREQ = 4'h1,
    ST_SWAIT = 4'h3,
    ST_SFILL = 4'h2,
    ST_PRIMARY_TAG_COPY = 4'h6,
    ST_PREQ = 4'h7,
    ST_PWAIT = 4'h5,
    ST_CBREQ = 4'h4,
    ST_CBWAIT = 4'hC
  } ctl_state_e;
endpackage

// >>> scc_fifo_if.sv
// Handshake bundle between the snoop controller and its stream FIFO
`timescale 1ns/1ps
interface scc_fifo_if #(parameter int W = 64);
  logic push_valid;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [W-1:0] pop_data;
  modport store (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
  modport feed (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data);
endinterface

// >>> scc_fifo.sv
// Stream FIFO between system bus fill beats and the processor
`timescale 1ns/1ps
module scc_fifo #(
  parameter int W = 64,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Data path
  scc_fifo_if.store port
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
    logic ready;
    logic valid;
    logic [W-1:0] head;
  } fifo_s;
  fifo_s q;
  fifo_s d;
  logic push;
  logic pop;

  // Pointer and count update; flags and head word registered from the next state
  always_comb
  begin
    push = port.push_valid && q.ready;
    pop = port.pop_ready && q.valid;
    d = q;
    if (push)
    begin
      d.mem[q.wr] = port.push_data;
      d.wr = q.wr + 1'b1;
    end
    if (pop)
      d.rd = q.rd + 1'b1;
    d.cnt = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    d.ready = d.cnt != (AW+1)'(DEPTH);
    d.valid = d.cnt != '0;
    d.head = d.mem[d.rd]; // Oldest word, so the read data leave a flop
  end

  // State register; empty after reset
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      q <= '0;
    else
      q <= d;
  end

  // Ready, valid and read data straight from flops
  assign port.push_ready = q.ready;
  assign port.pop_valid = q.valid;
  assign port.pop_data = q.head;
endmodule

// >>> scc_snoop_ctl.sv
// Snoop and coherency controller of a secondary cache
`timescale 1ns/1ps
module scc_snoop_ctl #(
  parameter int LINES = scc_pkg::LINES,
  parameter int FIFO_DEPTH = scc_pkg::FIFO_DEPTH
) (
  // Clock, reset and line size strap
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic line64_pin,
  // Processor requests
  input wire logic cpu_req,
  input wire logic [scc_pkg::ADDR_W-1:0] cpu_addr,
  input wire logic cpu_imod,
  input wire logic cpu_global,
  input wire logic [scc_pkg::DATA_W-1:0] cpu_wdata,
  output logic cpu_done,
  output logic cpu_retry,
  output logic [scc_pkg::DATA_W-1:0] store_data,
  // Fill stream to the processor
  output logic str_valid,
  output logic [scc_pkg::DATA_W-1:0] str_data,
  input wire logic str_ready,
  // Processor bus primary cache invalidate
  output logic pbus_req,
  input wire logic pbus_grant,
  output logic pinv_start,
  output logic [scc_pkg::ADDR_W-1:0] pinv_addr,
  input wire logic pinv_done,
  // System bus master side
  output logic sbus_req,
  input wire logic sbus_grant,
  output logic sbus_start,
  output scc_pkg::sys_kind_e sbus_kind,
  output logic sbus_global,
  output logic [scc_pkg::ADDR_W-1:0] sbus_addr,
  output logic [3:0] sbus_beats,
  input wire logic sbus_done,
  input wire logic sbus_retry,
  input wire logic sbus_shared,
  input wire logic sbus_rvalid,
  input wire logic [scc_pkg::DATA_W-1:0] sbus_rdata,
  output logic sbus_rready,
  // System bus snoop side
  input wire logic snp_valid,
  input wire logic [scc_pkg::ADDR_W-1:0] snp_addr,
  input wire scc_pkg::sys_kind_e snp_kind,
  input wire logic snp_global,
  output logic snp_retry
);
  localparam int AW = scc_pkg::ADDR_W;
  localparam int O32 = scc_pkg::OFS_32;
  localparam int O64 = scc_pkg::OFS_64;
  localparam int IW = $clog2(LINES);
  localparam int TW = AW - O32;

  typedef struct packed {
    scc_pkg::ctl_state_e st;
    logic s1;
    logic l64;
    scc_pkg::line_state_e [LINES-1:0] lst;
    logic [LINES-1:0][TW-1:0] tag;
    logic [LINES-1:0][1:0] primary_tag_copy;
    logic [AW-1:0] addr;
    logic imod;
    logic glob;
    logic pend;
    logic [AW-1:0] saddr;
    logic [IW-1:0] sidx;
    logic cb;
    logic cb_imod;
    logic half;
    logic [3:0] beat;
    logic shared;
    logic [scc_pkg::DATA_W-1:0] wdata;
    logic cpu_done;
    logic cpu_retry;
    logic snp_retry;
    logic pbus_req;
    logic pinv_start;
    logic [AW-1:0] pinv_addr;
    logic sbus_req;
    logic sbus_start;
    scc_pkg::sys_kind_e sbus_kind;
    logic sbus_global;
    logic [AW-1:0] sbus_addr;
    logic [3:0] sbus_beats;
  } ctl_s;
  ctl_s q;
  ctl_s d;

  function automatic logic [IW-1:0] line_idx(input logic [AW-1:0] a, input logic l64);
    line_idx = l64 ? a[O64 +: IW] : a[O32 +: IW];
  endfunction

  function automatic logic tag_eq(input logic [TW-1:0] t, input logic [AW-1:0] a,
                                  input logic l64);
    tag_eq = l64 ? (t[TW-1:1] == a[AW-1:O64]) : (t == a[AW-1:O32]);
  endfunction

  logic [AW-1:0] lk_addr;
  logic [IW-1:0] c_idx;
  logic c_hit;
  logic [IW-1:0] s_idx;
  logic s_hit;
  logic snoop_go;
  logic same_line;
  logic hb;
  logic [3:0] nbeats;
  logic prim_next;

  scc_fifo_if #(.W(scc_pkg::DATA_W)) fifo ();

  scc_fifo #(.W(scc_pkg::DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .port(fifo.store)
  );

  // Tag lookups for the processor side and the snoop side
  assign lk_addr = (q.st == scc_pkg::ST_IDLE) ? cpu_addr : q.addr;
  assign c_idx = line_idx(lk_addr, q.l64);
  assign c_hit = (q.lst[c_idx] != scc_pkg::LS_INV) && tag_eq(q.tag[c_idx], lk_addr, q.l64);
  assign s_idx = line_idx(snp_addr, q.l64);
  assign s_hit = (q.lst[s_idx] != scc_pkg::LS_INV) && tag_eq(q.tag[s_idx], snp_addr, q.l64);
  assign snoop_go = snp_valid && snp_global && s_hit
                    && (q.st == scc_pkg::ST_IDLE || q.st == scc_pkg::ST_SREQ);
  assign same_line = q.l64 ? (snp_addr[AW-1:O64] == q.addr[AW-1:O64])
                           : (snp_addr[AW-1:O32] == q.addr[AW-1:O32]);
  assign hb = q.l64 & q.addr[O32];
  assign nbeats = q.l64 ? scc_pkg::BEATS_64 : scc_pkg::BEATS_32;

  // Next state of the whole controller
  always_comb
  begin
    d = q;
    prim_next = 1'b0;
    d.s1 = line64_pin;
    d.l64 = q.s1;
    d.cpu_done = 1'b0;
    d.cpu_retry = 1'b0;
    d.snp_retry = 1'b0;
    d.pinv_start = 1'b0;
    d.sbus_start = 1'b0;
    fifo.push_valid = 1'b0;
    fifo.push_data = sbus_rdata;
    fifo.pop_ready = str_ready;
    case (q.st)
      scc_pkg::ST_IDLE:
      begin
        if (!snoop_go && cpu_req)
        begin
          d.addr = cpu_addr;
          d.imod = cpu_imod;
          d.glob = cpu_global;
          d.pend = 1'b1;
          if (c_hit && cpu_imod && cpu_global && q.lst[c_idx] == scc_pkg::LS_SU)
          begin
            d.wdata = cpu_wdata;
            d.st = scc_pkg::ST_SREQ;
          end
          else if (c_hit)
          begin
            if (cpu_imod)
              d.lst[c_idx] = scc_pkg::LS_EM;
            d.cpu_done = 1'b1;
            d.pend = 1'b0;
          end
          else
            d.st = scc_pkg::ST_SREQ;
        end
      end
      scc_pkg::ST_SREQ:
      begin
        if (!snoop_go && sbus_grant)
        begin
          d.sbus_start = 1'b1;
          d.sbus_addr = q.addr;
          d.sbus_global = q.glob;
          d.beat = 4'h0;
          d.shared = 1'b0;
          if (c_hit)
          begin
            d.sbus_kind = scc_pkg::SK_INVAL;
            d.sbus_beats = 4'h0;
            d.st = scc_pkg::ST_SWAIT;
          end
          else
          begin
            d.sbus_kind = q.imod ? scc_pkg::SK_RWITM : scc_pkg::SK_READ;
            d.sbus_beats = nbeats;
            d.st = scc_pkg::ST_SFILL;
          end
        end
      end
      scc_pkg::ST_SWAIT:
      begin
        if (sbus_retry)
          d.st = scc_pkg::ST_SREQ;
        else if (sbus_done)
        begin
          d.lst[c_idx] = scc_pkg::LS_EM;
          d.primary_tag_copy[c_idx][hb] = 1'b1;
          d.cpu_done = 1'b1;
          d.pend = 1'b0;
          d.st = scc_pkg::ST_IDLE;
        end
      end
      scc_pkg::ST_SFILL:
      begin
        d.shared = q.shared | sbus_shared;
        if (sbus_retry)
          d.st = scc_pkg::ST_SREQ;
        else
        begin
          // Only the requested half of a 64-byte line reaches the processor
          fifo.push_valid = sbus_rvalid && q.beat != nbeats
                            && (!q.l64 || q.beat[scc_pkg::HALF_BEAT_BIT] == hb);
          if (sbus_rvalid && fifo.push_ready && q.beat != nbeats)
            d.beat = q.beat + 4'h1;
          if (sbus_done && q.beat == nbeats)
          begin
            d.tag[c_idx] = q.addr[AW-1:O32];
            d.primary_tag_copy[c_idx] = 2'b00;
            d.primary_tag_copy[c_idx][hb] = 1'b1;
            d.lst[c_idx] = q.imod ? scc_pkg::LS_EM
                         : (d.shared ? scc_pkg::LS_SU : scc_pkg::LS_EU);
            d.cpu_done = 1'b1;
            d.pend = 1'b0;
            d.st = scc_pkg::ST_IDLE;
          end
        end
      end
      scc_pkg::ST_PRIMARY_TAG_COPY:
      begin
        if (q.primary_tag_copy[q.sidx][q.half])
          d.st = scc_pkg::ST_PREQ;
        else
          prim_next = 1'b1;
      end
      scc_pkg::ST_PREQ:
      begin
        if (pbus_grant)
        begin
          d.pinv_start = 1'b1;
          d.pinv_addr = {q.saddr[AW-1:O64], q.l64 ? q.half : q.saddr[O32], {O32{1'b0}}};
          d.st = scc_pkg::ST_PWAIT;
        end
      end
      scc_pkg::ST_PWAIT:
      begin
        if (pinv_done)
        begin
          d.primary_tag_copy[q.sidx][q.half] = 1'b0;
          prim_next = 1'b1;
        end
      end
      scc_pkg::ST_CBREQ:
      begin
        if (sbus_grant)
        begin
          d.sbus_start = 1'b1;
          d.sbus_kind = scc_pkg::SK_COPYBACK;
          d.sbus_global = 1'b0;
          d.sbus_addr = {q.saddr[AW-1:O64], q.l64 ? 1'b0 : q.saddr[O32], {O32{1'b0}}};
          d.sbus_beats = nbeats;
          d.st = scc_pkg::ST_CBWAIT;
        end
      end
      scc_pkg::ST_CBWAIT:
      begin
        if (sbus_retry)
          d.st = scc_pkg::ST_CBREQ;
        else if (sbus_done)
        begin
          d.lst[q.sidx] = q.cb_imod ? scc_pkg::LS_INV : scc_pkg::LS_SU;
          d.cb = 1'b0;
          d.st = q.pend ? scc_pkg::ST_SREQ : scc_pkg::ST_IDLE;
        end
      end
      default:
        d.st = scc_pkg::ST_IDLE;
    endcase
    // Next half, copyback, or back to the pending request
    if (prim_next)
    begin
      if (q.l64 && !q.half)
      begin
        d.half = 1'b1;
        d.st = scc_pkg::ST_PRIMARY_TAG_COPY;
      end
      else
        d.st = q.cb ? scc_pkg::ST_CBREQ : (q.pend ? scc_pkg::ST_SREQ : scc_pkg::ST_IDLE);
    end
    // Snoop hit takes over from an idle or waiting controller
    if (snoop_go)
    begin
      d.saddr = snp_addr;
      d.sidx = s_idx;
      d.half = 1'b0;
      d.cb = q.lst[s_idx] == scc_pkg::LS_EM && snp_kind != scc_pkg::SK_INVAL;
      d.cb_imod = snp_kind != scc_pkg::SK_READ;
      if (d.cb)
      begin
        d.snp_retry = 1'b1;
        d.st = scc_pkg::ST_PRIMARY_TAG_COPY;
      end
      else if (snp_kind == scc_pkg::SK_READ)
        d.lst[s_idx] = scc_pkg::LS_SU;
      else
      begin
        d.lst[s_idx] = scc_pkg::LS_INV;
        if (q.primary_tag_copy[s_idx] != 2'b00)
        begin
          d.st = scc_pkg::ST_PRIMARY_TAG_COPY;
          if (q.st == scc_pkg::ST_SREQ && same_line)
          begin
            d.cpu_retry = 1'b1;
            d.pend = 1'b0;
          end
        end
      end
    end
    d.sbus_req = d.st == scc_pkg::ST_SREQ || d.st == scc_pkg::ST_CBREQ;
    d.pbus_req = d.st == scc_pkg::ST_PREQ;
  end

  // State register; all-zero is idle with every line invalid
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      q <= '0;
    else
      q <= d;
  end

  // Outputs from flops
  assign cpu_done = q.cpu_done;
  assign cpu_retry = q.cpu_retry;
  assign store_data = q.wdata;
  assign str_valid = fifo.pop_valid;
  assign str_data = fifo.pop_data;
  assign pbus_req = q.pbus_req;
  assign pinv_start = q.pinv_start;
  assign pinv_addr = q.pinv_addr;
  assign sbus_req = q.sbus_req;
  assign sbus_start = q.sbus_start;
  assign sbus_kind = q.sbus_kind;
  assign sbus_global = q.sbus_global;
  assign sbus_addr = q.sbus_addr;
  assign sbus_beats = q.sbus_beats;
  assign sbus_rready = fifo.push_ready;
  assign snp_retry = q.snp_retry;

  // Checks on the coherency behaviour
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  property p_snp_retry;
    snoop_go && q.lst[s_idx] == scc_pkg::LS_EM && snp_kind != scc_pkg::SK_INVAL
      |=> snp_retry && q.st == scc_pkg::ST_PRIMARY_TAG_COPY;
  endproperty
  a_snp_retry: assert property (p_snp_retry) else $error("modified hit not retried");
  property p_share;
    snoop_go && snp_kind == scc_pkg::SK_READ && q.lst[s_idx] != scc_pkg::LS_EM
      |=> q.lst[q.sidx] == scc_pkg::LS_SU && !cpu_retry;
  endproperty
  a_share: assert property (p_share) else $error("clean snoop hit not shared");
  property p_inval;
    snoop_go && snp_kind == scc_pkg::SK_INVAL |=> q.lst[q.sidx] == scc_pkg::LS_INV;
  endproperty
  a_inval: assert property (p_inval) else $error("invalidate hit kept line");
  property p_cb_local;
    sbus_start && sbus_kind == scc_pkg::SK_COPYBACK |-> !sbus_global;
  endproperty
  a_cb_local: assert property (p_cb_local) else $error("copyback issued global");
  property p_cb_end;
    q.st == scc_pkg::ST_CBWAIT && sbus_done && !sbus_retry && !q.cb_imod
      |=> q.lst[q.sidx] == scc_pkg::LS_SU && $past(q.sbus_beats) == nbeats;
  endproperty
  a_cb_end: assert property (p_cb_end) else $error("copyback end state wrong");
  property p_cb_imod;
    q.st == scc_pkg::ST_CBWAIT && sbus_done && !sbus_retry && q.cb_imod
      |=> q.lst[q.sidx] == scc_pkg::LS_INV;
  endproperty
  a_cb_imod: assert property (p_cb_imod) else $error("modify copyback kept line");
  property p_inv_done;
    q.st == scc_pkg::ST_SWAIT && sbus_done && !sbus_retry
      |=> cpu_done && q.lst[$past(c_idx)] == scc_pkg::LS_EM;
  endproperty
  a_inv_done: assert property (p_inv_done) else $error("invalidate end not modified");
  property p_pinv;
    q.st == scc_pkg::ST_PREQ && pbus_grant |=> pinv_start ##1 !pinv_start && !pbus_req;
  endproperty
  a_pinv: assert property (p_pinv) else $error("primary invalidate not issued");
  property p_reeval;
    q.st == scc_pkg::ST_SREQ && sbus_grant && !snoop_go && !c_hit
      |=> sbus_start && sbus_kind != scc_pkg::SK_INVAL;
  endproperty
  a_reeval: assert property (p_reeval) else $error("lost line still invalidated");
  c_fill: cover property (q.st == scc_pkg::ST_SFILL && sbus_done && q.beat == nbeats);
  c_copyback: cover property (sbus_start && sbus_kind == scc_pkg::SK_COPYBACK);
  c_cpu_retry: cover property (cpu_retry ##[1:40] pinv_start);
endmodule

// >>> scc_far_model.sv
// Behavioural processor and system bus facing the snoop controller
`timescale 1ns/1ps
module scc_far_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Scenario controls from the bench
  input wire logic hold_gnt,
  input wire logic retry_arm,
  input wire logic shared_cmd,
  input wire logic stall,
  // System bus
  input wire logic sbus_req,
  input wire logic sbus_start,
  input wire scc_pkg::sys_kind_e sbus_kind,
  input wire logic [3:0] sbus_beats,
  input wire logic sbus_rready,
  output logic sbus_grant,
  output logic sbus_done,
  output logic sbus_retry,
  output logic sbus_shared,
  output logic sbus_rvalid,
  output logic [63:0] sbus_rdata,
  // Processor bus
  input wire logic pbus_req,
  input wire logic pinv_start,
  output logic pbus_grant,
  output logic pinv_done,
  output logic str_ready
);
  logic fill_on, retried;
  logic [3:0] beat_n, beat_max;
  logic [1:0] cb_wait, pi_wait;
  // Beat data follows the beat index; an idle bus shows the inverse
  assign sbus_rdata = sbus_rvalid ? 64'hA0 + 64'(beat_n) : ~(64'hA0 + 64'(beat_n));
  // Arbiter, fill beats, retries and the processor's invalidate answer
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      {sbus_grant, sbus_done, sbus_retry, sbus_shared, sbus_rvalid} <= '0;
      {pbus_grant, pinv_done, str_ready, fill_on, retried} <= '0;
      {beat_n, beat_max, cb_wait, pi_wait} <= '0;
    end
    else
    begin
      sbus_grant <= sbus_req && !sbus_grant && !hold_gnt;
      pbus_grant <= pbus_req && !pbus_grant;
      str_ready <= !stall && !str_ready;
      sbus_shared <= shared_cmd && fill_on;
      sbus_retry <= 1'b0;
      sbus_done <= cb_wait == 2'h1;
      pinv_done <= pi_wait == 2'h1;
      if (pinv_start)
        pi_wait <= 2'h2;
      else if (pi_wait != 2'h0)
        pi_wait <= pi_wait - 2'h1;
      if (!retry_arm)
        retried <= 1'b0;
      if (sbus_start && retry_arm && !retried)
      begin
        sbus_retry <= 1'b1;
        retried <= 1'b1;
      end
      else if (sbus_start && (sbus_kind == scc_pkg::SK_READ || sbus_kind == scc_pkg::SK_RWITM))
      begin
        fill_on <= 1'b1;
        beat_n <= 4'h0;
        beat_max <= sbus_beats;
      end
      else if (sbus_start)
        cb_wait <= 2'h3;
      else if (cb_wait != 2'h0)
        cb_wait <= cb_wait - 2'h1;
      // One idle cycle between beats keeps the fill slow
      if (fill_on && sbus_rvalid && sbus_rready)
      begin
        sbus_rvalid <= 1'b0;
        beat_n <= beat_n + 4'h1;
      end
      else if (fill_on && !sbus_rvalid && beat_n != beat_max)
        sbus_rvalid <= 1'b1;
      else if (fill_on && !sbus_rvalid)
      begin
        fill_on <= 1'b0;
        sbus_done <= 1'b1;
      end
    end
  end
endmodule

// >>> tb_top.sv
// Self-checking bench of the secondary cache snoop controller
`timescale 1ns/1ps
`define CHK(a, e) \
  begin \
    num_checks++; \
    if ((a) !== (e)) \
    begin \
      error_cnt++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); \
    end \
  end
module tb_top;
  logic clk_sys, reset_n, line64_pin, cpu_req, cpu_imod, cpu_global, cpu_done, cpu_retry;
  logic str_valid, str_ready, pbus_req, pbus_grant, pinv_start, pinv_done, sbus_req;
  logic sbus_grant, sbus_start, sbus_global, sbus_done, sbus_retry, sbus_shared;
  logic sbus_rvalid, sbus_rready, snp_valid, snp_global, snp_retry;
  logic hold_gnt, retry_arm, shared_cmd, stall;
  logic [31:0] cpu_addr, pinv_addr, sbus_addr, snp_addr;
  logic [63:0] cpu_wdata, store_data, str_data, sbus_rdata;
  logic [3:0] sbus_beats;
  scc_pkg::sys_kind_e sbus_kind, snp_kind;
  int error_cnt, num_checks, cyc_n, done_n, start_n, pinv_n, retry_n, sdone_n, str_n;
  scc_snoop_ctl dut (
    .clk_sys, .reset_n, .line64_pin, .cpu_req, .cpu_addr, .cpu_imod, .cpu_global,
    .cpu_wdata, .cpu_done, .cpu_retry, .store_data, .str_valid, .str_data, .str_ready,
    .pbus_req, .pbus_grant, .pinv_start, .pinv_addr, .pinv_done, .sbus_req, .sbus_grant,
    .sbus_start, .sbus_kind, .sbus_global, .sbus_addr, .sbus_beats, .sbus_done,
    .sbus_retry, .sbus_shared, .sbus_rvalid, .sbus_rdata, .sbus_rready, .snp_valid,
    .snp_addr, .snp_kind, .snp_global, .snp_retry
  );
  scc_far_model far (
    .clk_sys, .reset_n, .hold_gnt, .retry_arm, .shared_cmd, .stall, .sbus_req,
    .sbus_start, .sbus_kind, .sbus_beats, .sbus_rready, .sbus_grant, .sbus_done,
    .sbus_retry, .sbus_shared, .sbus_rvalid, .sbus_rdata, .pbus_req, .pinv_start,
    .pbus_grant, .pinv_done, .str_ready
  );
  // 200 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Pulse tallies taken at the sampling edge, plus the hang limit
  always @(posedge clk_sys)
  begin
    done_n += int'(cpu_done === 1'b1);
    start_n += int'(sbus_start === 1'b1);
    pinv_n += int'(pinv_start === 1'b1);
    retry_n += int'(cpu_retry === 1'b1);
    sdone_n += int'(sbus_done === 1'b1);
    str_n += int'(str_valid === 1'b1 && str_ready === 1'b1);
    cyc_n++;
    if (cyc_n == 20000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  function automatic int tally(input int sel);
    case (sel)
      0: return done_n;
      1: return start_n;
      2: return pinv_n;
      3: return retry_n;
      default: return sdone_n;
    endcase
  endfunction
  // Waits until a tally reaches its target, bounded
  task automatic await(input int sel, input int tgt);
    int n;
    n = 0;
    while (tally(sel) < tgt && n < 300)
    begin
      tick();
      n++;
    end
    `CHK(tally(sel), tgt)
  endtask
  task automatic cpu_go(input logic [31:0] a, input logic m, input logic [63:0] d);
    cpu_addr = a;
    cpu_imod = m;
    cpu_wdata = d;
    cpu_req = 1'b1;
    tick();
    cpu_req = 1'b0;
  endtask
  task automatic snoop(input logic [31:0] a, input scc_pkg::sys_kind_e k, input logic rt);
    snp_addr = a;
    snp_kind = k;
    snp_valid = 1'b1;
    tick();
    snp_valid = 1'b0;
    `CHK(snp_retry, rt)
  endtask
  task automatic wait_req();
    int n;
    n = 0;
    while (sbus_req !== 1'b1 && n < 50)
    begin
      tick();
      n++;
    end
    `CHK(sbus_req, 1'b1)
  endtask
  // A line fill: half h of a 64-byte line, or all of a 32-byte line with h 0
  task automatic fill(input scc_pkg::sys_kind_e k, input int h, input int tgt);
    int n, w, s;
    s = str_n;
    await(1, start_n + 1);
    `CHK(sbus_kind, k)
    `CHK(sbus_beats, line64_pin ? scc_pkg::BEATS_64 : scc_pkg::BEATS_32)
    `CHK(sbus_global, 1'b1)
    w = 0;
    n = 0;
    while (w < 4 && n < 300)
    begin
      if (str_valid === 1'b1 && str_ready === 1'b1)
      begin
        `CHK(str_data, 64'hA0 + 64'(4 * h + w))
        w++;
      end
      tick();
      n++;
    end
    await(0, tgt);
    tick();
    `CHK(str_n, s + 4)
  endtask
  // Snoop on a modified line: retry, primary invalidate, copyback
  task automatic t_snoop_cb(input logic [31:0] a, input scc_pkg::sys_kind_e k);
    int p;
    p = pinv_n + 1;
    snoop(a, k, 1'b1);
    await(2, p);
    `CHK(pinv_addr, a + 32'h20)
    `CHK(pbus_req, 1'b0)
    await(1, start_n + 1);
    `CHK(sbus_kind, scc_pkg::SK_COPYBACK)
    `CHK(sbus_global, 1'b0)
    `CHK(sbus_beats, scc_pkg::BEATS_64)
    `CHK(sbus_addr, a)
    await(4, sdone_n + 1);
    tick();
    `CHK(pinv_n, p)
  endtask
  task automatic t_eu_store();
    int s;
    s = start_n;
    cpu_go(32'h28, 1'b1, 64'h1);
    await(0, done_n + 1);
    `CHK(start_n, s)
  endtask
  task automatic t_clean_snoop();
    int p;
    p = pinv_n;
    snoop(32'h0, scc_pkg::SK_READ, 1'b0);
    repeat (20) tick();
    `CHK(pinv_n, p)
  endtask
  task automatic t_lost_wait();
    int r;
    r = retry_n;
    hold_gnt = 1'b1;
    cpu_go(32'h28, 1'b1, 64'h5);
    wait_req();
    snoop(32'h0, scc_pkg::SK_INVAL, 1'b0);
    hold_gnt = 1'b0;
    fill(scc_pkg::SK_RWITM, 1, done_n + 1);
    `CHK(retry_n, r)
  endtask
  task automatic t_retried_read();
    retry_arm = 1'b1;
    shared_cmd = 1'b1;
    cpu_go(32'h28, 1'b0, 64'h0);
    await(1, start_n + 1);
    `CHK(sbus_kind, scc_pkg::SK_READ)
    fill(scc_pkg::SK_READ, 1, done_n + 1);
    retry_arm = 1'b0;
    shared_cmd = 1'b0;
  endtask
  task automatic t_pending_inval();
    int r, p;
    r = retry_n + 1;
    p = pinv_n + 1;
    hold_gnt = 1'b1;
    cpu_go(32'h28, 1'b1, 64'h7);
    wait_req();
    snoop(32'h0, scc_pkg::SK_INVAL, 1'b0);
    await(3, r);
    await(2, p);
    `CHK(pinv_addr, 32'h20)
    hold_gnt = 1'b0;
    repeat (4) tick();
    cpu_go(32'h28, 1'b1, 64'h7);
    fill(scc_pkg::SK_RWITM, 1, done_n + 1);
  endtask
  task automatic t_shared_store();
    shared_cmd = 1'b1;
    cpu_go(32'h60, 1'b0, 64'h0);
    fill(scc_pkg::SK_READ, 1, done_n + 1);
    shared_cmd = 1'b0;
    cpu_go(32'h60, 1'b1, 64'h0123_4567_89AB_CDEF);
    await(1, start_n + 1);
    `CHK(sbus_kind, scc_pkg::SK_INVAL)
    `CHK(sbus_beats, 4'h0)
    `CHK(store_data, 64'h0123_4567_89AB_CDEF)
    await(0, done_n + 1);
    t_snoop_cb(32'h40, scc_pkg::SK_READ);
  endtask
  // Stalled processor: four half-line streams fill the FIFO
  task automatic t_fifo_full();
    int s, n;
    s = str_n;
    stall = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      cpu_go(32'hA0 + 32'(i) * 32'h40, 1'b0, 64'h0);
      await(0, done_n + 1);
    end
    `CHK(sbus_rready, 1'b0)
    `CHK(str_n, s)
    stall = 1'b0;
    n = 0;
    while (str_n < s + 16 && n < 200)
    begin
      tick();
      n++;
    end
    `CHK(str_n, s + 16)
    `CHK(str_valid, 1'b0)
  endtask
  // Second reset into 32-byte lines: a miss streams all four words
  task automatic t_line32();
    reset_n = 1'b0;
    line64_pin = 1'b0;
    tick();
    `CHK(sbus_rready, 1'b0)
    reset_n = 1'b1;
    repeat (3) tick();
    cpu_go(32'h28, 1'b0, 64'h0);
    fill(scc_pkg::SK_READ, 0, done_n + 1);
    `CHK(sbus_addr, 32'h28)
  endtask
  // Reset, then the scenarios in order
  initial
  begin
    {cpu_req, cpu_imod, snp_valid, hold_gnt, retry_arm, shared_cmd, stall} = '0;
    {line64_pin, cpu_global, snp_global} = 3'h7;
    {cpu_addr, snp_addr, cpu_wdata} = '0;
    snp_kind = scc_pkg::SK_READ;
    reset_n = 1'b0;
    repeat (16) @(posedge clk_sys);
    #1;
    `CHK(sbus_rready, 1'b0)
    reset_n = 1'b1;
    repeat (3) tick();
    cpu_go(32'h28, 1'b0, 64'h0);
    fill(scc_pkg::SK_READ, 1, done_n + 1);
    t_eu_store();
    t_snoop_cb(32'h0, scc_pkg::SK_READ);
    t_clean_snoop();
    t_lost_wait();
    t_snoop_cb(32'h0, scc_pkg::SK_RWITM);
    t_retried_read();
    t_pending_inval();
    t_shared_store();
    t_fifo_full();
    t_line32();
    give_verdict();
  end
endmodule
